// [include/brs_consts.vh]
`ifndef BRS_CONSTS_VH
`define BRS_CONSTS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define BRS_OFF_CTRL        12'h000
`define BRS_OFF_REL_FREQ    12'h004
`define BRS_OFF_REL_HOLD    12'h008
`define BRS_OFF_CUR_LIM     12'h00C
`define BRS_OFF_PULL_FREQ   12'h010
`define BRS_OFF_PULL_DELAY  12'h014
`define BRS_OFF_CLOSE_TIME  12'h018
`define BRS_OFF_STATUS      12'h01C

// ****************************************************************
// Field positions, reset values and limits
// ****************************************************************
`define BRS_CTRL_EN_BIT     0
`define BRS_RST_ENABLE      1'b0
`define BRS_RST_REL_FREQ    16'h00FA
`define BRS_RST_REL_HOLD    8'h0A
`define BRS_RST_CUR_LIM     12'h4B0
`define BRS_RST_PULL_FREQ   16'h0096
`define BRS_RST_PULL_DELAY  8'h00
`define BRS_RST_CLOSE_TIME  8'h0A
`define BRS_FREQ_MAX        16'h07D0
`define BRS_TIME_MAX        8'hC8
`define BRS_CUR_MIN         12'h1F4
`define BRS_CUR_MAX         12'h7D0

// ****************************************************************
// Timing
// ****************************************************************
`define BRS_CLK_HZ          100000000
`define BRS_TICK_S_TENTHS   1
`define BRS_TICK_CYCLES     ((`BRS_CLK_HZ / 10) * `BRS_TICK_S_TENTHS)

`endif

// [hdl/brs_tick_timer.v]
`include "brs_consts.vh"

// Counts 0.1 s ticks since the last restart and flags when the target is met.
module brs_tick_timer #(
    parameter TICK_CYCLES = `BRS_TICK_CYCLES
) (
    input wire pclk,
    input wire presetn,
    input wire restart,
    input wire [7:0] target,
    output reg done
);
    reg [26:0] div_q;
    reg [7:0] ticks_q;
    wire tick = (div_q == TICK_CYCLES - 1);

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_q <= 27'h0000000;
            ticks_q <= 8'h00;
            done <= 1'b0;
        end
        else if (restart)
        begin
            div_q <= 27'h0000000;
            ticks_q <= 8'h00;
            done <= 1'b0;
        end
        else
        begin
            div_q <= tick ? 27'h0000000 : div_q + 27'h0000001;
            if (tick && ticks_q != 8'hFF)
                ticks_q <= ticks_q + 8'h01;
            done <= (ticks_q >= target);
        end
    end
endmodule

// [hdl/brs_sequencer.v]
// Function
// - Enable bit, reset clear; when clear the brake sequence and output are idle.
// - On run, ramp the frequency up to the release frequency, 0 to 20 Hz.
// - At release frequency assert the brake-control output to release the brake.
// - While holding at release frequency, clamp output current to programmable limit.
// - Suspend acceleration for the hold time after release, then resume ramping.
// - On stop, decelerate to the pull-in frequency and hold it.
// - At pull-in frequency wait the delay, then drop the output to engage.
// - After the closing time with brake engaged, block output and stop.
`include "brs_consts.vh"

module brs_sequencer #(
    parameter TICK_CYCLES = `BRS_TICK_CYCLES
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire run_cmd,
    input wire [15:0] out_freq,
    output reg [15:0] freq_limit,
    output reg freq_limit_en,
    output reg accel_hold,
    output reg [11:0] cur_limit,
    output reg cur_limit_en,
    output reg brake_release,
    output reg output_block
);
    // ****************************************************************
    // States
    // ****************************************************************
    localparam [6:0] S_IDLE  = 7'b0000001;
    localparam [6:0] S_UP    = 7'b0000010;
    localparam [6:0] S_HOLD  = 7'b0000100;
    localparam [6:0] S_RUN   = 7'b0001000;
    localparam [6:0] S_DOWN  = 7'b0010000;
    localparam [6:0] S_DELAY = 7'b0100000;
    localparam [6:0] S_CLOSE = 7'b1000000;

    reg [1:0] run_sync_q;
    reg enable_q;
    reg [15:0] rel_freq_q;
    reg [7:0] rel_hold_q;
    reg [11:0] cur_lim_q;
    reg [15:0] pull_freq_q;
    reg [7:0] pull_delay_q;
    reg [7:0] close_time_q;
    reg [6:0] state_q;
    reg [6:0] state_d;
    reg [7:0] tgt;
    reg [31:0] rd;
    wire tmr_done;
    wire run = run_sync_q[1];
    wire wr_en = psel && penable && pwrite;

    function [15:0] clip_freq;
        input [31:0] v;
        begin
            clip_freq = (v[15:0] > `BRS_FREQ_MAX || v[31:16] != 16'h0000) ?
                `BRS_FREQ_MAX : v[15:0];
        end
    endfunction

    function [7:0] clip_time;
        input [31:0] v;
        begin
            clip_time = (v[7:0] > `BRS_TIME_MAX || v[31:8] != 24'h000000) ?
                `BRS_TIME_MAX : v[7:0];
        end
    endfunction

    // ****************************************************************
    // Register file
    // ****************************************************************
    // Out-of-range writes saturate so the sequence never sees an illegal value.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enable_q <= `BRS_RST_ENABLE;
            rel_freq_q <= `BRS_RST_REL_FREQ;
            rel_hold_q <= `BRS_RST_REL_HOLD;
            cur_lim_q <= `BRS_RST_CUR_LIM;
            pull_freq_q <= `BRS_RST_PULL_FREQ;
            pull_delay_q <= `BRS_RST_PULL_DELAY;
            close_time_q <= `BRS_RST_CLOSE_TIME;
        end
        else if (wr_en)
        begin
            case (paddr)
                `BRS_OFF_CTRL: enable_q <= pwdata[`BRS_CTRL_EN_BIT];
                `BRS_OFF_REL_FREQ: rel_freq_q <= clip_freq(pwdata);
                `BRS_OFF_REL_HOLD: rel_hold_q <= clip_time(pwdata);
                `BRS_OFF_CUR_LIM:
                begin
                    if (pwdata[31:12] != 20'h00000 || pwdata[11:0] > `BRS_CUR_MAX)
                        cur_lim_q <= `BRS_CUR_MAX;
                    else if (pwdata[11:0] < `BRS_CUR_MIN)
                        cur_lim_q <= `BRS_CUR_MIN;
                    else
                        cur_lim_q <= pwdata[11:0];
                end
                `BRS_OFF_PULL_FREQ: pull_freq_q <= clip_freq(pwdata);
                `BRS_OFF_PULL_DELAY: pull_delay_q <= clip_time(pwdata);
                `BRS_OFF_CLOSE_TIME: close_time_q <= clip_time(pwdata);
                default: ;
            endcase
        end
    end

    always @*
    begin
        case (paddr)
            `BRS_OFF_CTRL: rd = {31'h00000000, enable_q};
            `BRS_OFF_REL_FREQ: rd = {16'h0000, rel_freq_q};
            `BRS_OFF_REL_HOLD: rd = {24'h000000, rel_hold_q};
            `BRS_OFF_CUR_LIM: rd = {20'h00000, cur_lim_q};
            `BRS_OFF_PULL_FREQ: rd = {16'h0000, pull_freq_q};
            `BRS_OFF_PULL_DELAY: rd = {24'h000000, pull_delay_q};
            `BRS_OFF_CLOSE_TIME: rd = {24'h000000, close_time_q};
            `BRS_OFF_STATUS: rd = {22'h000000, brake_release, output_block, 1'b0, state_q};
            default: rd = 32'h00000000;
        endcase
    end

    // No wait states: setup cycle raises pready so access completes in its first cycle.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && (paddr > `BRS_OFF_STATUS || paddr[1:0] != 2'h0);
            if (psel && !penable && !pwrite)
                prdata <= rd;
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            run_sync_q <= 2'h0;
        else
            run_sync_q <= {run_sync_q[0], run_cmd};
    end

    always @*
    begin
        case (state_q)
            S_HOLD: tgt = rel_hold_q;
            S_DELAY: tgt = pull_delay_q;
            S_CLOSE: tgt = close_time_q;
            default: tgt = 8'hFF;
        endcase
    end

    brs_tick_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .restart(state_d != state_q),
        .target(tgt),
        .done(tmr_done)
    );

    always @*
    begin
        state_d = state_q;
        case (state_q)
            S_IDLE:
                if (run && enable_q)
                    state_d = S_UP;
            S_UP:
                if (!run)
                    state_d = S_DOWN;
                else if (out_freq >= rel_freq_q)
                    state_d = S_HOLD;
            S_HOLD:
                if (!run)
                    state_d = S_DOWN;
                else if (tmr_done)
                    state_d = S_RUN;
            S_RUN:
                if (!run)
                    state_d = S_DOWN;
            S_DOWN:
                if (out_freq <= pull_freq_q)
                    state_d = S_DELAY;
            S_DELAY:
                if (tmr_done)
                    state_d = S_CLOSE;
            S_CLOSE:
                if (tmr_done)
                    state_d = S_IDLE;
            default: state_d = S_IDLE;
        endcase
        if (!enable_q)
            state_d = S_IDLE;
    end

    // Outputs other than cur_limit are registered from the next state so they align with the state change.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= S_IDLE;
            freq_limit <= 16'h0000;
            freq_limit_en <= 1'b0;
            accel_hold <= 1'b0;
            cur_limit <= 12'h000;
            cur_limit_en <= 1'b0;
            brake_release <= 1'b0;
            output_block <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            freq_limit_en <= (state_d & (S_UP | S_HOLD | S_DOWN | S_DELAY | S_CLOSE)) != 7'h00;
            freq_limit <= (state_d == S_UP || state_d == S_HOLD) ?
                rel_freq_q : pull_freq_q;
            accel_hold <= (state_d == S_HOLD);
            cur_limit <= cur_lim_q;
            cur_limit_en <= (state_d == S_HOLD);
            brake_release <= (state_d & (S_HOLD | S_RUN | S_DOWN | S_DELAY)) != 7'h00;
            output_block <= (state_q == S_CLOSE && state_d == S_IDLE) ||
                (output_block && run_sync_q[1] == 1'b1 && state_d == S_IDLE) ? 1'b1 : 1'b0;
        end
    end
endmodule

// [tb/brs_props_properties.sv]
module brs_props (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic [11:0] paddr,
    input logic pready,
    input logic pslverr,
    input logic run_cmd,
    input logic [15:0] out_freq,
    input logic [15:0] freq_limit,
    input logic freq_limit_en,
    input logic accel_hold,
    input logic [11:0] cur_limit,
    input logic cur_limit_en,
    input logic brake_release,
    input logic output_block
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dcb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    answer_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    answer_single_a: assert property (pready |=> !pready)
        else $error("answer held too long");
    bad_addr_err_a: assert property (pready && paddr > 12'h01C |-> pslverr)
        else $error("no error on unmapped address");
    release_entry_a: assert property ($rose(brake_release) |-> freq_limit_en && out_freq >= freq_limit)
        else $error("release below release frequency");
    hold_clamp_a: assert property ($rose(brake_release) |-> accel_hold && cur_limit_en)
        else $error("hold not entered on release");
    clamp_range_a: assert property (cur_limit_en |-> cur_limit >= 12'h1F4 && cur_limit <= 12'h7D0)
        else $error("current clamp out of range");
    freq_range_a: assert property (freq_limit_en |-> freq_limit <= 16'h07D0)
        else $error("frequency ceiling out of range");
    engage_pullin_a: assert property ($fell(brake_release) |-> !accel_hold && out_freq <= freq_limit)
        else $error("brake engaged above pull-in frequency");
    stop_abort_a: assert property ($fell(run_cmd) |-> ##[1:6] !accel_hold)
        else $error("start sequence not abandoned");
    block_safe_a: assert property (output_block |-> !brake_release && !freq_limit_en)
        else $error("output blocked while released");
endmodule
bind brs_sequencer brs_props u_props (.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr,
    .run_cmd, .out_freq, .freq_limit, .freq_limit_en, .accel_hold, .cur_limit, .cur_limit_en,
    .brake_release, .output_block);

// [tb/brs_ramp_model.sv]
// ****************************************
// Ramp generator seen by the sequencer
// ****************************************
module brs_ramp_model #(
    parameter logic [15:0] SET_FREQ = 16'h0800,
    parameter logic [15:0] STEP = 16'h0010
) (
    input logic pclk,
    input logic presetn,
    input logic run_cmd,
    input logic [15:0] freq_limit,
    input logic freq_limit_en,
    input logic accel_hold,
    input logic output_block,
    output logic [15:0] out_freq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] tgt;
    assign tgt = freq_limit_en ? freq_limit : (run_cmd ? SET_FREQ : 16'h0000);
    // A held ramp may still slow down, so only acceleration is frozen.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn || output_block)
            out_freq <= 16'h0000;
        else if (out_freq < tgt && !accel_hold)
            out_freq <= (tgt - out_freq > STEP) ? out_freq + STEP : tgt;
        else if (out_freq > tgt)
            out_freq <= (out_freq - tgt > STEP) ? out_freq - STEP : tgt;
    end
endmodule

// [tb/brake_release_sequencer_test.sv]
module brake_release_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run_cmd = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, freq_limit_en, accel_hold, cur_limit_en, brake_release, output_block, e;
    logic [15:0] out_freq, freq_limit;
    logic [11:0] cur_limit;
    logic [31:0] rst_v [7] = '{32'h0, 32'hFA, 32'hA, 32'h4B0, 32'h96, 32'h0, 32'hA};
    int n_mismatch = 0, samples_checked = 0, n;
    always #5 pclk = ~pclk;
    brs_sequencer #(.TICK_CYCLES(10)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .run_cmd, .out_freq, .freq_limit, .freq_limit_en,
        .accel_hold, .cur_limit, .cur_limit_en, .brake_release, .output_block);
    brs_ramp_model ramp (.pclk, .presetn, .run_cmd, .freq_limit, .freq_limit_en, .accel_hold,
        .output_block, .out_freq);
    task tally_and_finish;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] x);
        samples_checked++;
        if (s !== x)
        begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, x);
        end
    endtask
    task tmo(input int k, input int lim);
        if (k >= lim)
        begin
            n_mismatch++;
            tally_and_finish;
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        tmo(k, 20);
    endtask
    task t_regs;
        for (int i = 0; i < 7; i++)
        begin
            apb(0, 12'(4 * i), 0);
            chk(r, rst_v[i]);
        end
        apb(0, 12'h01C, 0);
        chk(r, 32'h1);
        apb(0, 12'h020, 0);
        chk(e, 1);
        apb(1, 12'h004, 32'hFFFF);
        apb(0, 12'h004, 0);
        chk(r, 32'h7D0);
        apb(1, 12'h004, 32'hFA);
        apb(1, 12'h00C, 32'h0);
        apb(0, 12'h00C, 0);
        chk(r, 32'h1F4);
        apb(1, 12'h00C, 32'h4B0);
    endtask
    task t_disabled;
        run_cmd <= 1;
        repeat (300) @(posedge pclk);
        chk(brake_release, 0);
        chk(freq_limit_en, 0);
        run_cmd <= 0;
        for (n = 0; n < 500 && out_freq !== 16'h0; n++) @(posedge pclk);
        tmo(n, 500);
    endtask
    // Both sequences share one shape; only the timer settings and the stop moment differ.
    task t_seq(input int stop_at, input int hold, input int dly, input int cls);
        run_cmd <= 1;
        for (n = 0; n < 2000 && brake_release !== 1'b1; n++) @(posedge pclk);
        tmo(n, 2000);
        chk(out_freq >= 16'h00FA, 1);
        chk(cur_limit, 12'h4B0);
        chk(cur_limit_en, 1);
        chk(freq_limit, 16'h00FA);
        chk(accel_hold, 1);
        for (n = 0; n < stop_at && accel_hold === 1'b1; n++) @(posedge pclk);
        if (n < stop_at)
            chk(n >= hold * 10 - 1 && n <= hold * 10 + 3, 1);
        run_cmd <= 0;
        for (n = 0; n < 10 && accel_hold === 1'b1; n++) @(posedge pclk);
        tmo(n, 10);
        chk(n <= 6, 1);
        for (n = 0; n < 2000 && out_freq > 16'h0096; n++) @(posedge pclk);
        tmo(n, 2000);
        for (n = 0; n < 2000 && brake_release === 1'b1; n++) @(posedge pclk);
        tmo(n, 2000);
        chk(n >= dly * 10 && n <= dly * 10 + 4, 1);
        chk(freq_limit, 16'h0096);
        chk(freq_limit_en, 1);
        for (n = 0; n < 2000 && output_block !== 1'b1; n++) @(posedge pclk);
        tmo(n, 2000);
        chk(n >= cls * 10 - 1 && n <= cls * 10 + 3, 1);
        for (n = 0; n < 500 && out_freq !== 16'h0; n++) @(posedge pclk);
        tmo(n, 500);
    endtask
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1;
        t_regs;
        t_disabled;
        apb(1, 12'h000, 32'h1);
        t_seq(1000, 10, 0, 10);
        apb(1, 12'h008, 32'h5); // Longer than the brake needs to open.
        apb(1, 12'h014, 32'h3);
        apb(1, 12'h018, 32'h2);
        t_seq(20, 5, 3, 2);
        tally_and_finish;
    end
endmodule
